// ---- rtl/aac_pkg.sv ----
/*
  Shared constants and types for the converter control block: register map
  over APB, field positions, reset values, timing figures, state types.
  Assumes a 20 MHz system clock and an external converter core.
*/
// Notes on behaviour
// - turbo cycle time from divider code and oscillator
// - eight channels configured each on its own
// - mode, direction and drive bits choose channel type
// - digital outputs follow the output level register
// - comparator events may update digital outputs
// - input level register shows every channel level
// - 3-bit averaging factor shared by analog channels
// - averaged result is 16 bits wide
// - host starts first conversion, device does rest
// - bus-read averaging holds SCL low until done
// - start bit with statistics; poll done flag
// - start-bit results land in recent result registers
// - autonomous mode averages enabled channels in turn
// - comparator uses top 12 bits of average
// - CRC checking only while CRC enable set
// - CRC polynomial x8+x2+x+1
// - CRC register starts from zero
// - host sends CRC after each data byte
// - CRC mismatch blocks command, sets error flag
// - device sends CRC after each byte sent
package aac_pkg;
  // register byte addresses
  localparam logic [7:0] A_GEN  = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_TIME = 8'h08;
  localparam logic [7:0] A_AVG  = 8'h0c;
  localparam logic [7:0] A_MODE = 8'h10;
  localparam logic [7:0] A_DIR  = 8'h14;
  localparam logic [7:0] A_DRV  = 8'h18;
  localparam logic [7:0] A_OUT  = 8'h1c;
  localparam logic [7:0] A_IN   = 8'h20;
  localparam logic [7:0] A_SEQ  = 8'h24;
  localparam logic [7:0] A_MAN  = 8'h28;
  localparam logic [7:0] A_HI   = 8'h2c;
  localparam logic [7:0] A_LO   = 8'h30;
  localparam logic [7:0] A_EVT  = 8'h34;
  localparam logic [7:0] A_EEN  = 8'h38;
  localparam logic [7:0] A_EVAL = 8'h3c;
  localparam logic [7:0] A_RES  = 8'h40;
  localparam logic [7:0] A_REND = 8'h80;
  // field positions
  localparam int GEN_CRC   = 0;
  localparam int GEN_STATS = 1;
  localparam int GEN_CONVERSION_START_BIT = 2;
  localparam int GEN_SEQ   = 3;
  localparam int GEN_TURBO = 4;
  localparam int ST_DONE   = 0;
  localparam int ST_CRCERR = 1;
  localparam int ST_BUSY   = 2;
  localparam int TM_OSC    = 4;
  // reset values
  localparam logic [11:0] THR_HI_RST = 12'hfff;
  localparam logic [11:0] THR_LO_RST = 12'h000;
  // timing figures, picoseconds
  localparam longint unsigned CLK_PERIOD_PS = 50000;
  localparam longint unsigned T_COMP_PS     = 312500;
  localparam longint unsigned T_AVG_PS      = 1000000;
  localparam int unsigned     OSC_SLOW_MUL  = 32;
  // crc and link
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;
  localparam logic [6:0] I2C_ADDR = 7'h2a; // arbitrary value
  typedef enum logic [1:0] {E_IDLE, E_CONV, E_GAP} aac_eng_t;
  typedef enum logic [1:0] {S_I2C, S_CNV, S_SEQ, S_TURBO} aac_src_t;
  typedef enum logic [2:0] {I_IDLE, I_ADDR, I_WRX, I_ACK1, I_ACK2,
                            I_STR, I_RTX, I_RACK} aac_i2c_t;
  // apb response carrier
  typedef struct packed {
    logic        ok;
    logic [31:0] data;
  } aac_rd_t;
endpackage : aac_pkg

// ---- rtl/aac_top.sv ----
/*
  Converter control: APB register file, channel pin control, averaging
  engine with turbo and autonomous pacing, window events, I2C data port
  with optional CRC and SCL stretching.
  Assumes an external converter core on the same clock and I2C pins
  asynchronous to REF_CLK_I.
*/
`timescale 1ns/1ns
module aac_top
  import aac_pkg::*;
#(
  parameter int unsigned SLOW_MUL = OSC_SLOW_MUL
) (
  input  wire logic        REF_CLK_I,
  input  wire logic        RST_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  input  wire logic        SCL_I,
  output logic             SCL_O,
  output logic             SCL_OE_N_O,
  input  wire logic        SDA_I,
  output logic             SDA_O,
  output logic             SDA_OE_N_O,
  input  wire logic [7:0]  CH_I,
  output logic      [7:0]  CH_O,
  output logic      [7:0]  CH_OE_N_O,
  output logic             ADC_START_O,
  output logic      [2:0]  ADC_CH_O,
  input  wire logic        ADC_DONE_I,
  input  wire logic [11:0] ADC_DATA_I
);

  typedef struct packed {
    logic [7:0]       ch_a, ch_b;
    logic [1:0]       ln_a, ln_b, ln_p;
    logic             crc_en, statistics_enable, seq_on, turbo, osc;
    logic [3:0]       clk_div;
    logic [2:0]       averaging_factor;
    logic [7:0]       mode, dir, drv, outv, seq_en, evt, evt_en, evt_val;
    logic [2:0]       man_ch;
    logic [11:0]      thr_hi, thr_lo;
    logic [7:0][15:0] recent;
    logic             avg_done, crc_err, cnv_req, i2c_req, i2c_rdy;
    aac_eng_t         eng;
    aac_src_t         src;
    logic [2:0]       ch;
    logic [7:0]       left;
    logic [18:0]      acc;
    logic [19:0]      tmr;
    logic [15:0]      res;
    aac_i2c_t         ist;
    logic [2:0]       bits;
    logic [7:0]       sh, hold, ridx;
    logic             rw, crc_ph, bad;
    logic [1:0]       widx, tidx;
    logic             pready, pslverr;
    logic [31:0]      prdata;
    logic             scl_oe_n, sda_oe_n, pin_lo;
    logic [7:0]       ch_o, ch_oe_n;
    logic             adc_go;
    logic [2:0]       adc_ch;
  } aac_st_t;

  aac_st_t q, d;

  // crc of one byte, msb first, preset zero, no inversion
  function automatic logic [7:0] crc8(input logic [7:0] b);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = 7; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ b[i]) ? CRC_POLY : 8'h00);
    end
    return c;
  endfunction : crc8

  // pacing period in clock cycles for one sample
  function automatic logic [19:0] cyc(input logic [3:0] dv, input logic osc,
                                      input logic tb);
    longint unsigned t;
    t = tb ? T_COMP_PS : T_AVG_PS;
    t = t * (dv[0] ? 64'd3 : 64'd2);
    t = t << dv[3:1];
    if (osc) begin
      t = t * longint'(SLOW_MUL);
    end
    t = t / (64'd2 * CLK_PERIOD_PS);
    if (t == 64'd0) begin
      t = 64'd1;
    end
    return t[19:0];
  endfunction : cyc

  // next enabled channel after cur, wrapping
  function automatic logic [2:0] next_ch(input logic [2:0] cur,
                                         input logic [7:0] en);
    logic [2:0] n;
    n = cur;
    for (int i = 8; i >= 1; i--) begin
      if (en[3'(cur + 3'(i))]) begin
        n = 3'(cur + 3'(i));
      end
    end
    return n;
  endfunction : next_ch

  // register read view
  function automatic aac_rd_t reg_rd(input aac_st_t s, input logic [7:0] a);
    aac_rd_t r;
    r = '{ok: 1'b1, data: 32'h0};
    case (a)
      A_GEN:  r.data[4:0] = {s.turbo, s.seq_on, 1'b0, s.statistics_enable, s.crc_en};
      A_STAT: r.data[2:0] = {s.eng != E_IDLE, s.crc_err, s.avg_done};
      A_TIME: r.data[4:0] = {s.osc, s.clk_div};
      A_AVG:  r.data[2:0] = s.averaging_factor;
      A_MODE: r.data[7:0] = s.mode;
      A_DIR:  r.data[7:0] = s.dir;
      A_DRV:  r.data[7:0] = s.drv;
      A_OUT:  r.data[7:0] = s.outv;
      A_IN:   r.data[7:0] = s.ch_b;
      A_SEQ:  r.data[7:0] = s.seq_en;
      A_MAN:  r.data[2:0] = s.man_ch;
      A_HI:   r.data[11:0] = s.thr_hi;
      A_LO:   r.data[11:0] = s.thr_lo;
      A_EVT:  r.data[7:0] = s.evt;
      A_EEN:  r.data[7:0] = s.evt_en;
      A_EVAL: r.data[7:0] = s.evt_val;
      default: begin
        if (a >= A_RES && a < A_REND && a[1:0] == 2'b00) begin
          r.data[7:0] = a[2] ? s.recent[a[5:3]][15:8]
                             : s.recent[a[5:3]][7:0];
        end else begin
          r.ok = 1'b0;
        end
      end
    endcase
    return r;
  endfunction : reg_rd

  // register write; link writes other than to A_GEN and A_STAT blocked while crc error stands
  function automatic aac_st_t reg_wr(input aac_st_t s, input logic [7:0] a,
                                     input logic [31:0] w, input logic lk);
    aac_st_t n;
    n = s;
    if (!(lk && s.crc_err && a != A_GEN && a != A_STAT)) begin
      case (a)
        A_GEN: begin
          n.crc_en   = w[GEN_CRC];
          n.statistics_enable = w[GEN_STATS];
          n.seq_on   = w[GEN_SEQ];
          n.turbo    = w[GEN_TURBO];
          n.cnv_req  = s.cnv_req | w[GEN_CONVERSION_START_BIT];
        end
        A_STAT: begin
          n.avg_done = s.avg_done & ~w[ST_DONE];
          n.crc_err  = s.crc_err & ~w[ST_CRCERR];
        end
        A_TIME: {n.osc, n.clk_div} = w[4:0];
        A_AVG:  n.averaging_factor = w[2:0];
        A_MODE: n.mode = w[7:0];
        A_DIR:  n.dir = w[7:0];
        A_DRV:  n.drv = w[7:0];
        A_OUT:  n.outv = w[7:0];
        A_SEQ:  n.seq_en = w[7:0];
        A_MAN:  n.man_ch = w[2:0];
        A_HI:   n.thr_hi = w[11:0];
        A_LO:   n.thr_lo = w[11:0];
        A_EVT:  n.evt = s.evt & ~w[7:0];
        A_EEN:  n.evt_en = w[7:0];
        A_EVAL: n.evt_val = w[7:0];
        default: n = s;
      endcase
    end
    return n;
  endfunction : reg_wr

  logic [18:0] acc_n;
  logic [7:0]  left_n;
  logic [15:0] avg_r;
  logic [7:0]  rx_b;
  logic [7:0]  tx_b;
  logic [1:0]  tidx_n;
  logic        scl, sda, rise, fall, start_c, stop_c, go;
  aac_src_t    go_src;
  logic [2:0]  go_ch;
  aac_rd_t     rd;

  // next state of the whole block
  always_comb begin
    d       = q;
    acc_n   = '0;
    left_n  = '0;
    avg_r   = '0;
    rx_b    = '0;
    tx_b    = '0;
    tidx_n  = '0;
    go      = 1'b0;
    go_src  = S_I2C;
    go_ch   = q.man_ch;
    rd      = reg_rd(q, PADDR_I);
    // input synchronisers
    d.ch_a   = CH_I;
    d.ch_b   = q.ch_a;
    d.ln_a   = {SCL_I, SDA_I};
    d.ln_b   = q.ln_a;
    d.ln_p   = q.ln_b;
    d.adc_go = 1'b0;
    d.pin_lo = 1'b0;
    // apb slave, one wait state
    d.pready = 1'b0;
    if (PSEL_I && PENABLE_I && !q.pready) begin
      d.pready  = 1'b1;
      d.pslverr = !rd.ok;
      d.prdata  = PWRITE_I ? 32'h0 : rd.data;
    end
    if (PSEL_I && PENABLE_I && q.pready && PWRITE_I && !q.pslverr) begin
      d = reg_wr(d, PADDR_I, PWDATA_I, 1'b0);
    end
    // conversion engine
    case (q.eng)
      E_IDLE: begin
        if (q.i2c_req) begin
          go = 1'b1;
        end else if (q.cnv_req) begin
          go     = 1'b1;
          go_src = S_CNV;
        end else if (q.turbo) begin
          go     = 1'b1;
          go_src = S_TURBO;
        end else if (q.seq_on && |q.seq_en) begin
          go     = 1'b1;
          go_src = S_SEQ;
          go_ch  = next_ch(q.ch, q.seq_en);
        end
        if (go) begin
          d.eng    = E_CONV;
          d.src    = go_src;
          d.ch     = go_ch;
          d.adc_ch = go_ch;
          d.adc_go = 1'b1;
          d.acc    = '0;
          d.left   = (go_src == S_TURBO) ? 8'd1 : (8'd1 << q.averaging_factor);
          if (go_src == S_I2C) begin
            d.i2c_req = 1'b0;
          end
          if (go_src == S_CNV) begin
            d.cnv_req = 1'b0;
          end
        end
      end
      E_CONV: begin
        if (ADC_DONE_I) begin
          acc_n  = 19'(q.acc + {7'h00, ADC_DATA_I});
          left_n = 8'(q.left - 8'd1);
          d.acc  = acc_n;
          d.left = left_n;
          d.eng  = E_GAP;
          d.tmr  = cyc(q.clk_div, q.osc, q.src == S_TURBO);
          if (left_n == 8'd0) begin
            avg_r = 16'((23'(acc_n) << 4) >> q.averaging_factor);
            d.recent[q.ch] = avg_r;
            if (avg_r[15:4] > q.thr_hi || avg_r[15:4] < q.thr_lo) begin
              d.evt[q.ch] = 1'b1;
              if (q.evt_en[q.ch]) begin
                d.outv[q.ch] = q.evt_val[q.ch];
              end
            end
            if (q.src == S_CNV) begin
              d.avg_done = 1'b1;
            end
            if (q.src == S_I2C) begin
              d.res     = avg_r;
              d.i2c_rdy = 1'b1;
            end
          end
        end
      end
      E_GAP: begin
        d.tmr = 20'(q.tmr - 20'd1);
        if (q.tmr <= 20'd1) begin
          if (q.left != 8'd0) begin
            d.eng    = E_CONV;
            d.adc_go = 1'b1;
          end else begin
            d.eng = E_IDLE;
          end
        end
      end
      default: d.eng = E_IDLE;
    endcase
    // i2c data port
    scl     = q.ln_b[1];
    sda     = q.ln_b[0];
    rise    = scl && !q.ln_p[1];
    fall    = !scl && q.ln_p[1];
    start_c = scl && q.ln_p[1] && q.ln_p[0] && !sda;
    stop_c  = scl && q.ln_p[1] && !q.ln_p[0] && sda;
    rx_b    = {q.sh[6:0], sda};
    tidx_n  = 2'(q.tidx + (q.crc_en ? 2'd1 : 2'd2));
    case (q.tidx)
      2'd0:    tx_b = q.res[15:8];
      2'd1:    tx_b = crc8(q.res[15:8]);
      2'd2:    tx_b = q.res[7:0];
      default: tx_b = crc8(q.res[7:0]);
    endcase
    case (q.ist)
      I_ADDR, I_WRX: begin
        if (rise) begin
          d.sh   = rx_b;
          d.bits = 3'(q.bits + 3'd1);
          if (q.bits == 3'd7 && q.ist == I_ADDR) begin
            d.rw  = sda;
            d.ist = (rx_b[7:1] == I2C_ADDR) ? I_ACK1 : I_IDLE;
          end else if (q.bits == 3'd7) begin
            d.ist = I_ACK1;
            if (q.crc_en && q.crc_ph) begin
              d.crc_ph = 1'b0;
              if (crc8(q.hold) != rx_b) begin
                d.bad     = 1'b1;
                d.crc_err = 1'b1;
              end
            end else begin
              d.hold   = rx_b;
              d.crc_ph = q.crc_en;
            end
            // byte complete: data alone, or data with its crc
            if (!(q.crc_en && !q.crc_ph)) begin
              if (q.widx == 2'd0) begin
                d.ridx = q.crc_en ? q.hold : rx_b;
                d.widx = 2'd1;
              end else if (!(q.bad || d.bad)) begin
                d = reg_wr(d, {q.ridx[5:0], 2'b00},
                           {24'h0, q.crc_en ? q.hold : rx_b}, 1'b1);
              end
            end
          end
        end
      end
      I_ACK1: begin
        if (fall) begin
          d.sda_oe_n = 1'b0;
          d.ist      = I_ACK2;
        end
      end
      I_ACK2: begin
        if (fall) begin
          d.sda_oe_n = 1'b1;
          d.bits     = 3'd0;
          if (q.rw) begin
            d.scl_oe_n = 1'b0;
            d.i2c_req  = 1'b1;
            d.i2c_rdy  = 1'b0;
            d.ist      = I_STR;
          end else begin
            d.ist = I_WRX;
          end
        end
      end
      I_STR: begin
        if (q.i2c_rdy) begin
          d.i2c_rdy  = 1'b0;
          d.tidx     = 2'd0;
          d.sh       = q.res[15:8];
          d.sda_oe_n = q.res[15];
          d.scl_oe_n = 1'b1;
          d.bits     = 3'd0;
          d.ist      = I_RTX;
        end
      end
      I_RTX: begin
        if (fall) begin
          d.bits = 3'(q.bits + 3'd1);
          if (q.bits == 3'd7) begin
            d.sda_oe_n = 1'b1;
            d.ist      = I_RACK;
          end else begin
            d.sh       = {q.sh[6:0], 1'b0};
            d.sda_oe_n = q.sh[6];
          end
        end
      end
      I_RACK: begin
        if (rise && sda) begin
          d.ist = I_IDLE;
        end else if (fall) begin
          d.bits = 3'd0;
          if (tidx_n < q.tidx || tidx_n == 2'd0) begin
            d.scl_oe_n = 1'b0;
            d.i2c_req  = 1'b1;
            d.ist      = I_STR;
          end else begin
            d.tidx     = tidx_n;
            d.sh       = (tidx_n == 2'd1) ? crc8(q.res[15:8]) :
                         (tidx_n == 2'd2) ? q.res[7:0] : crc8(q.res[7:0]);
            d.sda_oe_n = d.sh[7];
            d.ist      = I_RTX;
          end
        end
      end
      default: d.ist = I_IDLE;
    endcase
    if (start_c) begin
      d.ist      = I_ADDR;
      d.bits     = 3'd0;
      d.widx     = 2'd0;
      d.crc_ph   = 1'b0;
      d.bad      = 1'b0;
      d.sda_oe_n = 1'b1;
    end else if (stop_c) begin
      d.ist      = I_IDLE;
      d.sda_oe_n = 1'b1;
    end
    // channel pins
    for (int i = 0; i < 8; i++) begin
      d.ch_o[i]    = d.drv[i] & d.outv[i];
      d.ch_oe_n[i] = !(d.mode[i] && d.dir[i] &&
                       (d.drv[i] || !d.outv[i]));
    end
  end

  // state register
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      q          <= '0;
      q.ln_a     <= 2'b11;
      q.ln_b     <= 2'b11;
      q.ln_p     <= 2'b11;
      q.thr_hi   <= THR_HI_RST;
      q.thr_lo   <= THR_LO_RST;
      q.scl_oe_n <= 1'b1;
      q.sda_oe_n <= 1'b1;
      q.ch_oe_n  <= 8'hff;
    end else begin
      q <= d;
    end
  end

  assign PRDATA_O    = q.prdata;
  assign PREADY_O    = q.pready;
  assign PSLVERR_O   = q.pslverr;
  assign SCL_O       = q.pin_lo;
  assign SCL_OE_N_O  = q.scl_oe_n;
  assign SDA_O       = q.pin_lo;
  assign SDA_OE_N_O  = q.sda_oe_n;
  assign CH_O        = q.ch_o;
  assign CH_OE_N_O   = q.ch_oe_n;
  assign ADC_START_O = q.adc_go;
  assign ADC_CH_O    = q.adc_ch;

endmodule : aac_top

// ---- testbench/aac_top_sva.sv ----
/*
  Port assertions for the converter control block: APB answer timing,
  refusal of unmapped places, pin idle levels, converter start pulse.
  Assumes a bind onto aac_top and a single clock domain.
*/
`timescale 1ns/1ns
module aac_top_sva
  import aac_pkg::*;
#(
  parameter int unsigned SLOW_MUL = OSC_SLOW_MUL
) (
  input wire logic        REF_CLK_I,
  input wire logic        RST_I,
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [7:0]  PADDR_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic        PREADY_O,
  input wire logic        PSLVERR_O,
  input wire logic        SCL_O,
  input wire logic        SDA_O,
  input wire logic        SCL_OE_N_O,
  input wire logic        SDA_OE_N_O,
  input wire logic [7:0]  CH_OE_N_O,
  input wire logic        ADC_START_O
);
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);
  // access phase waiting, then a one-cycle answer
  sequence s_wait;
    PSEL_I && PENABLE_I && !PREADY_O;
  endsequence
  sequence s_answer;
    ##1 PREADY_O ##1 !PREADY_O;
  endsequence
  a_apb_one_wait: assert property (s_wait |-> s_answer)
    else $error("apb answer not one cycle after access");
  a_ready_cause: assert property (
    PREADY_O |-> $past(PSEL_I && PENABLE_I))
    else $error("ready without access");
  a_mapped_ok: assert property (
    PREADY_O && $past(PADDR_I) < A_REND && $past(PADDR_I[1:0]) == 2'b00
    |-> !PSLVERR_O)
    else $error("error on mapped register");
  a_unmapped_err: assert property (
    PREADY_O && $past(PADDR_I) >= A_REND |-> PSLVERR_O)
    else $error("no error on unmapped address");
  a_err_read_zero: assert property (
    PSLVERR_O && !$past(PWRITE_I) |-> PRDATA_O == 32'h0)
    else $error("refused read not zero");
  a_pins_open_drain: assert property (
    SCL_O == 1'b0 && SDA_O == 1'b0)
    else $error("i2c pin driven high");
  a_start_pulse: assert property (ADC_START_O |=> !ADC_START_O)
    else $error("start pulse longer than one cycle");
  a_reset_analog: assert property (
    $fell(RST_I) |-> CH_OE_N_O == 8'hff && SCL_OE_N_O && SDA_OE_N_O)
    else $error("pins driven after reset");
endmodule : aac_top_sva

// ---- testbench/aac_i2c_host.sv ----
/*
  I2C host model: register writes with optional per-byte CRC.
  Assumes pull-ups on the wires and honours SCL stretching.
*/
`timescale 1ns/1ns
module aac_i2c_host
  import aac_pkg::*;
(
  output logic      scl_o,
  output logic      sda_o,
  input  wire logic scl_w,
  input  wire logic sda_w
);
  localparam int HALF = 200;
  logic ack_all;
  // crc of one byte on its own
  function automatic logic [7:0] crc8(input logic [7:0] b);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 7; i >= 0; i--) begin // msb first, no invert
      c = {c[6:0], 1'b0} ^ ((c[7] ^ b[i]) ? 8'h07 : 8'h00);
    end
    return c;
  endfunction : crc8
  // one bit; waits while the device stretches
  task automatic bit_io(input logic b, output logic r);
    sda_o = b;
    #HALF;
    scl_o = 1'b1;
    for (int k = 0; k < 20000 && scl_w !== 1'b1; k++) #10;
    #HALF;
    r = sda_w;
    scl_o = 1'b0;
  endtask : bit_io
  task automatic byte_tx(input logic [7:0] b, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r);
    end
    bit_io(1'b1, r);
    a = ~r;
  endtask : byte_tx
  // data byte, then its crc when enabled
  task automatic send(input logic [7:0] b, input logic crc,
                      input logic bad);
    logic a;
    byte_tx(b, a);
    ack_all &= a;
    if (crc) begin
      byte_tx(crc8(b) ^ {7'h00, bad}, a);
      ack_all &= a;
    end
  endtask : send
  task automatic reg_write(input logic [7:0] idx, input logic [7:0] val,
                           input logic crc, input logic bad,
                           output logic ack);
    logic a;
    ack_all = 1'b1;
    sda_o = 1'b1;
    scl_o = 1'b1;
    #HALF;
    sda_o = 1'b0;
    #HALF;
    scl_o = 1'b0;
    byte_tx({I2C_ADDR, 1'b0}, a); // no crc after address
    ack_all &= a;
    send(idx, crc, 1'b0);
    send(val, crc, bad);
    sda_o = 1'b0;
    #HALF;
    scl_o = 1'b1;
    #HALF;
    sda_o = 1'b1;
    #HALF;
    ack = ack_all;
  endtask : reg_write
  // read one result byte; waits out the device's SCL stretch
  task automatic reg_read(output logic [7:0] val);
    logic a;
    #HALF;
    sda_o = 1'b0;
    #HALF;
    scl_o = 1'b0;
    byte_tx({I2C_ADDR, 1'b1}, a);
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, val[i]);
    end
    bit_io(1'b1, a); // no ack ends the read
    sda_o = 1'b0;
    #HALF;
    scl_o = 1'b1;
    #HALF;
    sda_o = 1'b1;
    #HALF;
  endtask : reg_read
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
endmodule : aac_i2c_host

// ---- testbench/test_adc_channel_avg_crc_control.sv ----
/*
  Self-checking bench: APB registers, channel pins, averaging, turbo
  pacing, I2C writes with CRC. Assumes SLOW_MUL 2 and a converter
  model here answering three cycles after each start.
*/
`timescale 1ns/1ns
module test_adc_channel_avg_crc_control;
  import aac_pkg::*;
  logic        clk, rst, psel, pen, pwr, adone, slv, ack;
  logic        pready, pslverr, scl_h, sda_h, scl_o, sda_o;
  logic        scl_oe_n, sda_oe_n, astart;
  logic        scl_w, sda_w;
  logic [2:0]  ach, ach_seen, mch;
  logic [7:0]  paddr, ch_in, ch_o, ch_oe_n, ext, m, d, v, o, oe, rb;
  logic [11:0] adata, smp;
  logic [31:0] pwdata, prdata, rdata;
  int          err_total, checks, cyc, cnt, nst, sum, last_done, gap;
  int          seed, e16, osr_tab[3], tm_tab[3], g[3];
  assign scl_w = scl_h & (scl_oe_n | scl_o);
  assign sda_w = sda_h & (sda_oe_n | sda_o);
  assign ch_in = (ch_oe_n & ext) | (~ch_oe_n & ch_o);
  aac_top #(.SLOW_MUL(2)) i_aac_top (
    .REF_CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .SCL_I(scl_w), .SCL_O(scl_o), .SCL_OE_N_O(scl_oe_n),
    .SDA_I(sda_w), .SDA_O(sda_o), .SDA_OE_N_O(sda_oe_n),
    .CH_I(ch_in), .CH_O(ch_o), .CH_OE_N_O(ch_oe_n),
    .ADC_START_O(astart), .ADC_CH_O(ach), .ADC_DONE_I(adone),
    .ADC_DATA_I(adata));
  aac_i2c_host i_aac_i2c_host (
    .scl_o(scl_h), .sda_o(sda_h), .scl_w(scl_w), .sda_w(sda_w));
  // converter model: done three cycles after start, random sample
  always @(posedge clk) begin
    cyc <= cyc + 1;
    adone <= (cnt == 1);
    if (cnt == 1) last_done <= cyc;
    if (astart === 1'b1) begin
      cnt <= 3;
      smp = 12'($urandom);
      adata <= smp;
      sum += smp;
      nst++;
      gap <= cyc - last_done;
      ach_seen <= ach;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end
    if (cyc == 40000) begin
      err_total++;
      tally_and_finish();
    end
  end
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // one apb transfer, then an idle cycle
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdata = prdata;
    slv = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic rd_chk(input string nm, input logic [7:0] a,
                        input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, rdata, exp);
  endtask : rd_chk
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    {rst, psel, pen, pwr, adone} = 5'b10000;
    {paddr, pwdata, adata, ext} = '0;
    {err_total, checks, cyc, cnt, nst, sum, last_done, gap} = '0;
    osr_tab = '{0, 3, 7};
    tm_tab = '{32'h00, 32'h02, 32'h10};
    seed = $urandom(29);
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // reset values and refusal
    rd_chk("thr_hi", A_HI, 32'(THR_HI_RST));
    rd_chk("mode_rst", A_MODE, 32'h0);
    rd_chk("unmapped", A_REND, 32'h0);
    chk("slverr", slv, 32'h1);
    $display("test reset done");
    // channel configuration and levels
    for (int k = 0; k < 4; k++) begin
      {m, d, v, o} = $urandom;
      ext <= 8'($urandom);
      apb(1'b1, A_MODE, m);
      apb(1'b1, A_DIR, d);
      apb(1'b1, A_DRV, v);
      apb(1'b1, A_OUT, o);
      repeat (4) @(posedge clk);
      oe = ~(m & d & (v | ~o));
      chk("oe_n", ch_oe_n, oe);
      chk("ch_o", ch_o & m & d, m & d & v & o);
      rd_chk("in_lvl", A_IN, (oe & ext) | (~oe & o));
    end
    $display("test channels done");
    // start-bit averaging over several factors
    for (int k = 0; k < 3; k++) begin
      mch = 3'($urandom);
      apb(1'b1, A_AVG, osr_tab[k]);
      apb(1'b1, A_MAN, mch);
      sum = 0;
      nst = 0;
      apb(1'b1, A_GEN, 32'h6);
      for (int t = 0; t < 2000; t++) begin
        apb(1'b0, A_STAT, 32'h0);
        if (rdata[ST_DONE] === 1'b1) break;
      end
      chk("starts", nst, 1 << osr_tab[k]);
      chk("chan", ach_seen, mch);
      e16 = ((sum << 4) >> osr_tab[k]) & 16'hffff;
      rd_chk("res_lo", 8'(A_RES + 8 * mch), e16 & 8'hff);
      rd_chk("res_hi", 8'(A_RES + 4 + 8 * mch), e16 >> 8);
      repeat (20) @(posedge clk); // pacing gap ends, busy falls
      apb(1'b1, A_STAT, 32'h1);
      rd_chk("done_clr", A_STAT, 32'h0);
    end
    $display("test averaging done");
    // turbo pacing: code step and slow oscillator
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, A_TIME, tm_tab[k]);
      if (k == 0) apb(1'b1, A_GEN, 32'h10);
      repeat (300) @(posedge clk);
      g[k] = gap;
    end
    apb(1'b1, A_GEN, 32'h0);
    repeat (50) @(posedge clk);
    chk("turbo_step", g[1] - g[0], 32'd6);
    chk("turbo_slow", g[2], g[1]);
    $display("test turbo done");
    // link writes without and with crc
    i_aac_i2c_host.reg_write(8'h04, 8'h5a, 1'b0, 1'b0, ack);
    @(posedge clk);
    chk("ack", ack, 32'h1);
    rd_chk("plain", A_MODE, 32'h5a);
    // link read: averaged result sent after SCL stretch
    apb(1'b1, A_AVG, 32'h3);
    {sum, nst} = '0;
    i_aac_i2c_host.reg_read(rb);
    @(posedge clk);
    e16 = ((sum << 4) >> 3) & 16'hffff;
    chk("rd_starts", nst, 32'd8);
    chk("i2c_rd", rb, e16 >> 8);
    apb(1'b1, A_GEN, 32'h1);
    i_aac_i2c_host.reg_write(8'h04, 8'h3c, 1'b1, 1'b0, ack);
    @(posedge clk);
    rd_chk("crc_ok", A_MODE, 32'h3c);
    i_aac_i2c_host.reg_write(8'h04, 8'hc3, 1'b1, 1'b1, ack);
    @(posedge clk);
    rd_chk("crc_bad", A_MODE, 32'h3c);
    rd_chk("crc_flag", A_STAT, 32'h2);
    apb(1'b1, A_STAT, 32'h2);
    rd_chk("flag_clr", A_STAT, 32'h0);
    $display("test link done");
    tally_and_finish();
  end
endmodule : test_adc_channel_avg_crc_control
bind aac_top aac_top_sva #(.SLOW_MUL(SLOW_MUL)) i_aac_top_sva (
  .REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .PSEL_I(PSEL_I),
  .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
  .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
  .SCL_O(SCL_O), .SDA_O(SDA_O), .SCL_OE_N_O(SCL_OE_N_O),
  .SDA_OE_N_O(SDA_OE_N_O), .CH_OE_N_O(CH_OE_N_O),
  .ADC_START_O(ADC_START_O));
